// ==== verilog/ser_status_regs.sv ====
/*
  Status event reporting registers: operational and questionable groups,
  each with a real-time condition, a read-clear event latch and an enable
  mask, plus the two summary bits of the status byte.
  Assumes condition flags arrive asynchronously from the instrument and
  that the command port is driven by logic on I_MCLK.
*/
// Notes on behaviour
// - status byte bit 7 is OR of operational events enabled by mask.
// - operational mask write stores the supplied value as enable bits.
// - operational mask read returns stored value with no side effect.
// - operational events latch every condition event and clear when read.
// - operational condition shows voltage mode at bit 8, current mode bit 10.
// - preset loads operational mask 8193 and questionable mask 255.
// - questionable events latch only bits 13 and 12.
// - questionable bits 0 and 1 stay real-time and are never latched.
// - questionable events are read-only and clear when read.
// - questionable condition shows live flags, 1 active, 0 inactive.
// - questionable bits 1 and 0 may both be set while settling.
// - status byte bit 3 is OR of questionable events enabled by mask.
// - questionable layout bits 14,13,12,6,3,1,0 as named.
// - questionable mask read returns its stored value.
// - operational condition read returns live value, no latch or clear.
`timescale 1ns/100ps
module ser_status_regs (
  // clock, reset, enable
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic I_CE,
  // command port
  input wire logic I_CMD_VALID,
  input wire logic [3:0] I_CMD_CODE,
  input wire logic [15:0] I_CMD_DATA,
  output logic O_RSP_VALID,
  output logic [15:0] O_RSP_DATA,
  // raw condition flags from the instrument
  input wire logic [15:0] I_OPER_COND_RAW,
  input wire logic [15:0] I_QUES_COND_RAW,
  // status byte
  output logic [7:0] O_STATUS_BYTE
);

  localparam int W = ser_pkg::REG_W;

  // flag synchronisers and edge history
  logic [W-1:0] oper_s1_q, oper_s1_d;
  logic [W-1:0] oper_s2_q, oper_s2_d;
  logic [W-1:0] ques_s1_q, ques_s1_d;
  logic [W-1:0] ques_s2_q, ques_s2_d;
  logic [W-1:0] oper_prev_q, oper_prev_d;
  logic [W-1:0] ques_prev_q, ques_prev_d;
  logic [W-1:0] oper_cond, ques_cond;
  logic [W-1:0] oper_rise, ques_rise;

  // register state
  logic [W-1:0] oper_mask_q, oper_mask_d;
  logic [W-1:0] ques_mask_q, ques_mask_d;
  logic [W-1:0] oper_ev_q, oper_ev_d;
  logic [W-1:0] ques_ev_q, ques_ev_d;
  logic rsp_valid_q, rsp_valid_d;
  logic [W-1:0] rsp_data_q, rsp_data_d;

  ser_pkg::ser_cmd_t cmd;
  logic take;
  logic oper_clr, ques_clr;

  assign cmd = ser_pkg::ser_cmd_t'(I_CMD_CODE);
  assign take = I_CMD_VALID & I_CE;

  always_comb begin
    oper_s1_d = I_OPER_COND_RAW;
    ques_s1_d = I_QUES_COND_RAW;
    oper_s2_d = oper_s1_q;
    ques_s2_d = ques_s1_q;
    oper_prev_d = oper_cond;
    ques_prev_d = ques_cond;
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      oper_s1_q <= ser_pkg::COND_RESET;
      oper_s2_q <= ser_pkg::COND_RESET;
      ques_s1_q <= ser_pkg::COND_RESET;
      ques_s2_q <= ser_pkg::COND_RESET;
      oper_prev_q <= ser_pkg::COND_RESET;
      ques_prev_q <= ser_pkg::COND_RESET;
    end else if (I_CE) begin
      oper_s1_q <= oper_s1_d;
      oper_s2_q <= oper_s2_d;
      ques_s1_q <= ques_s1_d;
      ques_s2_q <= ques_s2_d;
      oper_prev_q <= oper_prev_d;
      ques_prev_q <= ques_prev_d;
    end
  end

  assign oper_cond = oper_s2_q & ser_pkg::OPER_USED_MASK;
  assign ques_cond = ques_s2_q & ser_pkg::QUES_USED_MASK;

  // an event is a flag going active
  assign oper_rise = oper_cond & ~oper_prev_q;
  // only current and voltage errors latch
  assign ques_rise = ques_cond & ~ques_prev_q & ser_pkg::QUES_LATCH_MASK;

  always_comb begin
    oper_clr = 1'b0;
    ques_clr = 1'b0;
    oper_mask_d = oper_mask_q;
    ques_mask_d = ques_mask_q;
    rsp_valid_d = 1'b0;
    rsp_data_d = rsp_data_q;
    if (take) begin
      rsp_valid_d = 1'b1;
      rsp_data_d = '0;
      unique case (cmd)
        ser_pkg::SER_CMD_OPER_COND_RD: rsp_data_d = oper_cond;
        ser_pkg::SER_CMD_OPER_MASK_WR: oper_mask_d = I_CMD_DATA;
        ser_pkg::SER_CMD_OPER_MASK_RD: rsp_data_d = oper_mask_q;
        ser_pkg::SER_CMD_OPER_EVENT_RD: begin
          rsp_data_d = oper_ev_q;
          oper_clr = 1'b1;
        end
        ser_pkg::SER_CMD_PRESET: begin
          oper_mask_d = ser_pkg::OPER_MASK_PRESET;
          ques_mask_d = ser_pkg::QUES_MASK_PRESET;
        end
        ser_pkg::SER_CMD_QUES_EVENT_RD: begin
          rsp_data_d = ques_ev_q;
          ques_clr = 1'b1;
        end
        ser_pkg::SER_CMD_QUES_COND_RD: rsp_data_d = ques_cond;
        ser_pkg::SER_CMD_QUES_MASK_WR: ques_mask_d = I_CMD_DATA;
        ser_pkg::SER_CMD_QUES_MASK_RD: rsp_data_d = ques_mask_q;
        default: rsp_data_d = '0;
      endcase
    end
    // a new event beats the read-clear
    oper_ev_d = (oper_clr ? ser_pkg::EVENT_RESET : oper_ev_q) | oper_rise;
    ques_ev_d = (ques_clr ? ser_pkg::EVENT_RESET : ques_ev_q) | ques_rise;
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      oper_mask_q <= ser_pkg::OPER_MASK_RESET;
      ques_mask_q <= ser_pkg::QUES_MASK_RESET;
      oper_ev_q <= ser_pkg::EVENT_RESET;
      ques_ev_q <= ser_pkg::EVENT_RESET;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= '0;
    end else if (I_CE) begin
      oper_mask_q <= oper_mask_d;
      ques_mask_q <= ques_mask_d;
      oper_ev_q <= oper_ev_d;
      ques_ev_q <= ques_ev_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_data_q <= rsp_data_d;
    end
  end

  assign O_RSP_VALID = rsp_valid_q;
  assign O_RSP_DATA = rsp_data_q;

  always_comb begin
    O_STATUS_BYTE = 8'h00;
    O_STATUS_BYTE[ser_pkg::SB_OPER_BIT] = |(oper_ev_q & oper_mask_q);
    O_STATUS_BYTE[ser_pkg::SB_QUES_BIT] = |(ques_ev_q & ques_mask_q);
  end

  // checks
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RST_N);

  a_oper_summary_or: assert property (
    (oper_ev_q[ser_pkg::OPER_CONST_VOLTAGE_BIT] && oper_mask_q[ser_pkg::OPER_CONST_VOLTAGE_BIT])
      |-> O_STATUS_BYTE[7])
    else $error("operational summary missing for enabled event");

  a_oper_mask_write: assert property (
    (take && cmd == ser_pkg::SER_CMD_OPER_MASK_WR) |=> (oper_mask_q == $past(I_CMD_DATA) && O_RSP_VALID))
    else $error("operational mask write not stored");

  a_oper_mask_read: assert property (
    (take && cmd == ser_pkg::SER_CMD_OPER_MASK_RD)
      |=> (O_RSP_VALID && O_RSP_DATA == $past(oper_mask_q) && oper_mask_q == $past(oper_mask_q)))
    else $error("operational mask read wrong or disturbed");

  a_oper_event_clear: assert property (
    (take && cmd == ser_pkg::SER_CMD_OPER_EVENT_RD)
      |=> (O_RSP_DATA == $past(oper_ev_q) && oper_ev_q == $past(oper_rise)))
    else $error("operational event read did not clear");

  a_oper_event_latch: assert property (
    (I_CE && oper_rise != '0) |=> ((oper_ev_q & $past(oper_rise)) == $past(oper_rise)))
    else $error("operational event lost");

  a_voltage_mode_bit: assert property (
    (I_CE && $rose(oper_s2_q[ser_pkg::OPER_CONST_VOLTAGE_BIT]))
      |=> oper_ev_q[ser_pkg::OPER_CONST_VOLTAGE_BIT])
    else $error("voltage mode entry not latched at bit 8");

  a_preset_masks: assert property (
    (take && cmd == ser_pkg::SER_CMD_PRESET) |=> (oper_mask_q == 16'h2001 && ques_mask_q == 16'h00FF))
    else $error("preset values wrong");

  a_ques_latch_only: assert property (
    (ques_ev_q & 16'hCFFF) == 16'h0000)
    else $error("questionable bit outside 13 and 12 latched");

  a_ques_event_clear: assert property (
    (take && cmd == ser_pkg::SER_CMD_QUES_EVENT_RD)
      |=> (O_RSP_DATA == $past(ques_ev_q) && ques_ev_q == $past(ques_rise)))
    else $error("questionable event read did not clear");

  a_ques_cond_live: assert property (
    (take && cmd == ser_pkg::SER_CMD_QUES_COND_RD)
      |=> (O_RSP_DATA[1:0] == $past(ques_s2_q[1:0]) && O_RSP_DATA[12] == $past(ques_s2_q[12])))
    else $error("questionable condition read not live");

  a_ques_summary_or: assert property (
    O_STATUS_BYTE[3] == |(ques_ev_q & ques_mask_q) && O_STATUS_BYTE[6:4] == 3'h0)
    else $error("questionable summary wrong");

  a_ques_mask_read: assert property (
    (take && cmd == ser_pkg::SER_CMD_QUES_MASK_RD) |=> O_RSP_DATA == $past(ques_mask_q))
    else $error("questionable mask read wrong");

  a_oper_cond_read: assert property (
    (take && cmd == ser_pkg::SER_CMD_OPER_COND_RD)
      |=> (O_RSP_DATA == ($past(oper_s2_q) & 16'h5F60) && oper_ev_q == $past(oper_ev_d)))
    else $error("operational condition read wrong");

  a_summary_clear_now: assert property (
    (take && cmd == ser_pkg::SER_CMD_OPER_EVENT_RD && oper_rise == '0) |=> !O_STATUS_BYTE[7])
    else $error("summary not dropped after event read");

  a_current_mode_bit: assert property (
    (I_CE && $rose(oper_s2_q[ser_pkg::OPER_CONST_CURRENT_BIT]))
      |=> oper_ev_q[ser_pkg::OPER_CONST_CURRENT_BIT])
    else $error("current mode entry not latched at bit 10");

  a_oper_event_hold: assert property (
    !(take && cmd == ser_pkg::SER_CMD_OPER_EVENT_RD)
      |=> ((oper_ev_q & $past(oper_ev_q)) == $past(oper_ev_q)))
    else $error("operational event dropped without a read");

  a_mode_faults_unlatched: assert property (
    (I_CE && ques_cond[1:0] != 2'b00) |=> (ques_ev_q[1:0] == 2'b00))
    else $error("questionable mode fault latched as event");

  a_ques_event_latch: assert property (
    (I_CE && ques_rise != '0) |=> ((ques_ev_q & $past(ques_rise)) == $past(ques_rise)))
    else $error("questionable event lost");

  a_ques_event_hold: assert property (
    !(take && cmd == ser_pkg::SER_CMD_QUES_EVENT_RD)
      |=> ((ques_ev_q & $past(ques_ev_q)) == $past(ques_ev_q)))
    else $error("questionable event dropped without a read");

  a_ques_cond_read: assert property (
    (take && cmd == ser_pkg::SER_CMD_QUES_COND_RD)
      |=> (O_RSP_VALID && O_RSP_DATA == ($past(ques_s2_q) & 16'h704B)))
    else $error("questionable condition read wrong");

  a_settling_pair: assert property (
    (ques_s2_q[1:0] == 2'b11) |-> (ques_cond[1:0] == 2'b11))
    else $error("settling pair not shown together");

  a_ques_unused_zero: assert property (
    (ques_cond & 16'h8FB4) == 16'h0000)
    else $error("unused questionable bit shown");

  a_ques_summary_set: assert property (
    (ques_ev_q[ser_pkg::QUES_CURRENT_ERROR_BIT] && ques_mask_q[ser_pkg::QUES_CURRENT_ERROR_BIT])
      |-> O_STATUS_BYTE[3])
    else $error("questionable summary missing for enabled event");

  a_oper_mask_hold: assert property (
    !(take && (cmd == ser_pkg::SER_CMD_OPER_MASK_WR || cmd == ser_pkg::SER_CMD_PRESET))
      |=> (oper_mask_q == $past(oper_mask_q)))
    else $error("operational mask changed without a write");

  a_ques_mask_hold: assert property (
    !(take && (cmd == ser_pkg::SER_CMD_QUES_MASK_WR || cmd == ser_pkg::SER_CMD_PRESET))
      |=> (ques_mask_q == $past(ques_mask_q)))
    else $error("questionable mask changed without a write");

  c_preset_seen: cover property (take && cmd == ser_pkg::SER_CMD_PRESET);
  c_oper_event_read: cover property (take && cmd == ser_pkg::SER_CMD_OPER_EVENT_RD && oper_ev_q != '0);
  c_settling_both: cover property (ques_cond[1] && ques_cond[0]);
  c_ques_summary: cover property ($rose(O_STATUS_BYTE[3]));
  c_current_mode: cover property ($rose(oper_cond[ser_pkg::OPER_CONST_CURRENT_BIT]));

endmodule : ser_status_regs

// ==== verilog/ser_pkg.sv ====
/*
  Shared constants for the status event reporting block: command codes,
  condition bit positions, used-bit masks, preset and reset mask values.
  Assumes a single clock domain and 16-bit status registers.
*/
package ser_pkg;

  localparam int REG_W = 16;

  // status byte summary positions
  localparam int SB_OPER_BIT = 7;
  localparam int SB_QUES_BIT = 3;

  // operational condition positions
  localparam int OPER_LIST_ACTIVE_BIT = 14;
  localparam int OPER_LIST_DONE_BIT = 12;
  localparam int OPER_SAMPLE_DONE_BIT = 11;
  localparam int OPER_CONST_CURRENT_BIT = 10;
  localparam int OPER_TRANSIENT_DONE_BIT = 9;
  localparam int OPER_CONST_VOLTAGE_BIT = 8;
  localparam int OPER_TRANSIENT_ARMED_BIT = 6;
  localparam int OPER_AWAITING_TRIGGER_BIT = 5;

  // questionable condition positions
  localparam int QUES_ABSORBING_ENERGY_BIT = 14;
  localparam int QUES_CURRENT_ERROR_BIT = 13;
  localparam int QUES_VOLTAGE_FAULT_BIT = 12;
  localparam int QUES_FOLLOWER_FAULT_BIT = 6;
  localparam int QUES_THERMAL_FAULT_BIT = 3;
  localparam int QUES_CURRENT_REG_FAULT_BIT = 1;
  localparam int QUES_VOLTAGE_REG_FAULT_BIT = 0;

  // implemented bits; unused bits read as zero
  localparam logic [REG_W-1:0] OPER_USED_MASK = 16'h5F60;
  localparam logic [REG_W-1:0] QUES_USED_MASK = 16'h704B;
  // only these questionable bits are ever latched as events
  localparam logic [REG_W-1:0] QUES_LATCH_MASK = 16'h3000;

  // mask values
  localparam logic [REG_W-1:0] OPER_MASK_RESET = 16'h0000;
  localparam logic [REG_W-1:0] QUES_MASK_RESET = 16'h0000;
  localparam logic [REG_W-1:0] OPER_MASK_PRESET = 16'h2001;
  localparam logic [REG_W-1:0] QUES_MASK_PRESET = 16'h00FF;

  localparam logic [REG_W-1:0] EVENT_RESET = 16'h0000;
  localparam logic [REG_W-1:0] COND_RESET = 16'h0000;

  typedef enum logic [3:0] {
    SER_CMD_OPER_COND_RD = 4'h0,
    SER_CMD_OPER_MASK_WR = 4'h1,
    SER_CMD_OPER_MASK_RD = 4'h2,
    SER_CMD_OPER_EVENT_RD = 4'h3,
    SER_CMD_PRESET = 4'h4,
    SER_CMD_QUES_EVENT_RD = 4'h5,
    SER_CMD_QUES_COND_RD = 4'h6,
    SER_CMD_QUES_MASK_WR = 4'h7,
    SER_CMD_QUES_MASK_RD = 4'h8
  } ser_cmd_t;

endpackage : ser_pkg

// ==== verification/ser_host_model.sv ====
/*
  Host model: issues one status command at a time on the command port.
  Assumes the command port is sampled on the rising edge of i_mclk.
*/
`timescale 1ns/100ps
module ser_host_model (
  // clock
  input wire logic i_mclk,
  // command side
  output logic o_cmd_valid,
  output logic [3:0] o_cmd_code,
  output logic [15:0] o_cmd_data,
  // answer side
  input wire logic i_rsp_valid,
  input wire logic [15:0] i_rsp_data
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_code = 4'h0;
    o_cmd_data = 16'h0000;
  end

  // one-cycle request, then wait a bounded time for the answer strobe
  task automatic cmd(input logic [3:0] code, input logic [15:0] data, output logic [15:0] rsp);
    int n;
    rsp = 16'hXXXX;
    @(negedge i_mclk);
    o_cmd_valid = 1'b1;
    o_cmd_code = code;
    o_cmd_data = data;
    @(posedge i_mclk);
    for (n = 0; n < 3; n++) begin
      @(negedge i_mclk);
      // released lines show the inverse so stale values are never trusted
      o_cmd_valid = 1'b0;
      o_cmd_code = ~code;
      o_cmd_data = ~data;
      if (i_rsp_valid === 1'b1) begin
        rsp = i_rsp_data;
        break;
      end
    end
  endtask : cmd
endmodule : ser_host_model

// ==== verification/tb_top.sv ====
/*
  Self-checking bench for the status event reporting registers.
  Assumes the host model drives commands and the bench drives the raw flags.
*/
`timescale 1ns/100ps
module tb_top;
  logic mclk;
  logic rst_n;
  logic ce;
  logic cmd_valid;
  logic [3:0] cmd_code;
  logic [15:0] cmd_data;
  logic rsp_valid;
  logic [15:0] rsp_data;
  logic [15:0] oper_raw;
  logic [15:0] ques_raw;
  logic [7:0] sb;
  int error_cnt;
  int checks;

  ser_status_regs ser_status_regs_i (
    .I_MCLK(mclk), .I_RST_N(rst_n), .I_CE(ce),
    .I_CMD_VALID(cmd_valid), .I_CMD_CODE(cmd_code), .I_CMD_DATA(cmd_data),
    .O_RSP_VALID(rsp_valid), .O_RSP_DATA(rsp_data),
    .I_OPER_COND_RAW(oper_raw), .I_QUES_COND_RAW(ques_raw), .O_STATUS_BYTE(sb)
  );

  ser_host_model ser_host_model_i (
    .i_mclk(mclk), .o_cmd_valid(cmd_valid), .o_cmd_code(cmd_code),
    .o_cmd_data(cmd_data), .i_rsp_valid(rsp_valid), .i_rsp_data(rsp_data)
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic rd(input logic [3:0] c, input logic [15:0] exp, input string what);
    logic [15:0] r;
    ser_host_model_i.cmd(c, 16'h0000, r);
    check(r, exp, what);
  endtask : rd

  task automatic wr(input logic [3:0] c, input logic [15:0] d);
    logic [15:0] r;
    ser_host_model_i.cmd(c, d, r);
  endtask : wr

  // new flags settle through sync and event latch within four cycles
  task automatic raw(input logic [15:0] o, input logic [15:0] q);
    @(negedge mclk);
    oper_raw = o;
    ques_raw = q;
    repeat (4) @(negedge mclk);
  endtask : raw

  task automatic sb_is(input logic [7:0] exp);
    @(negedge mclk);
    check({8'h00, sb}, {8'h00, exp}, "status byte");
  endtask : sb_is

  task automatic t_reset;
    rd(ser_pkg::SER_CMD_OPER_MASK_RD, 16'h0000, "oper mask reset");
    rd(ser_pkg::SER_CMD_QUES_MASK_RD, 16'h0000, "ques mask reset");
    rd(ser_pkg::SER_CMD_OPER_EVENT_RD, 16'h0000, "oper event reset");
    sb_is(8'h00);
  endtask : t_reset

  // flags change while the enable is low; the sync must not move until it returns
  task automatic t_freeze;
    @(negedge mclk);
    ce = 1'b0;
    oper_raw = 16'h0400;
    repeat (4) @(negedge mclk);
    ce = 1'b1;
    rd(ser_pkg::SER_CMD_OPER_COND_RD, 16'h0000, "frozen sync");
    rd(ser_pkg::SER_CMD_OPER_COND_RD, 16'h0400, "thawed cond");
    rd(ser_pkg::SER_CMD_OPER_EVENT_RD, 16'h0400, "event after thaw");
  endtask : t_freeze

  task automatic t_oper_cond;
    raw(16'h0100, 16'h0000);
    rd(ser_pkg::SER_CMD_OPER_COND_RD, 16'h0100, "const voltage");
    rd(ser_pkg::SER_CMD_OPER_COND_RD, 16'h0100, "cond reread");
    raw(16'h0400, 16'h0000);
    rd(ser_pkg::SER_CMD_OPER_COND_RD, 16'h0400, "const current");
    raw(16'hFFFF, 16'h0000);
    rd(ser_pkg::SER_CMD_OPER_COND_RD, ser_pkg::OPER_USED_MASK, "cond all");
    raw(16'h0000, 16'h0000);
    rd(ser_pkg::SER_CMD_OPER_EVENT_RD, 16'h5F60, "events latched");
  endtask : t_oper_cond

  task automatic t_oper_event;
    wr(ser_pkg::SER_CMD_OPER_MASK_WR, 16'h0400);
    rd(ser_pkg::SER_CMD_OPER_MASK_RD, 16'h0400, "oper mask");
    rd(ser_pkg::SER_CMD_OPER_MASK_RD, 16'h0400, "oper mask reread");
    raw(16'h0200, 16'h0000);
    sb_is(8'h00);
    raw(16'h0600, 16'h0000);
    sb_is(8'h80);
    rd(ser_pkg::SER_CMD_OPER_EVENT_RD, 16'h0600, "oper event");
    sb_is(8'h00);
    rd(ser_pkg::SER_CMD_OPER_EVENT_RD, 16'h0000, "oper event cleared");
    raw(16'h0000, 16'h0000);
    raw(16'h0400, 16'h0000);
    wr(ser_pkg::SER_CMD_OPER_MASK_WR, 16'h0000);
    sb_is(8'h00);
    wr(ser_pkg::SER_CMD_OPER_MASK_WR, 16'h0400);
    sb_is(8'h80);
    rd(ser_pkg::SER_CMD_OPER_EVENT_RD, 16'h0400, "oper event again");
  endtask : t_oper_event

  task automatic t_ques;
    raw(16'h0000, 16'h0003);
    rd(ser_pkg::SER_CMD_QUES_COND_RD, 16'h0003, "settling flags");
    rd(ser_pkg::SER_CMD_QUES_EVENT_RD, 16'h0000, "mode faults unlatched");
    raw(16'h0000, 16'h704B);
    rd(ser_pkg::SER_CMD_QUES_COND_RD, 16'h704B, "ques layout");
    rd(ser_pkg::SER_CMD_QUES_EVENT_RD, 16'h3000, "ques latch bits");
    rd(ser_pkg::SER_CMD_QUES_EVENT_RD, 16'h0000, "ques cleared");
    raw(16'h0000, 16'h0000);
    rd(ser_pkg::SER_CMD_QUES_COND_RD, 16'h0000, "ques inactive");
    wr(ser_pkg::SER_CMD_QUES_MASK_WR, 16'h1000);
    rd(ser_pkg::SER_CMD_QUES_MASK_RD, 16'h1000, "ques mask");
    raw(16'h0000, 16'h2000);
    sb_is(8'h00);
    raw(16'h0000, 16'h3000);
    sb_is(8'h08);
    rd(ser_pkg::SER_CMD_QUES_EVENT_RD, 16'h3000, "ques event");
    sb_is(8'h00);
  endtask : t_ques

  task automatic t_preset;
    wr(ser_pkg::SER_CMD_PRESET, 16'h0000);
    rd(ser_pkg::SER_CMD_OPER_MASK_RD, 16'h2001, "preset oper");
    rd(ser_pkg::SER_CMD_QUES_MASK_RD, 16'h00FF, "preset ques");
    rd(4'hF, 16'h0000, "unknown code");
  endtask : t_preset

  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    oper_raw = 16'h0000;
    ques_raw = 16'h0000;
    error_cnt = 0;
    checks = 0;
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    t_reset();
    t_oper_cond();
    t_oper_event();
    t_ques();
    t_preset();
    t_freeze();
    end_of_test();
  end

  // the tests need well under a thousand cycles
  initial begin
    #1000000;
    error_cnt++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule : tb_top
